// [hdl/acomp_b_pkg.sv]
// constants and types for the comparator b control and event block
package acomp_b_pkg;

    // register indices as printed and their byte addresses (index * 4)
    localparam logic [7:0]  REF_CTRL_IDX      = 8'hBD;
    localparam logic [7:0]  CTRL_STATUS_IDX   = 8'hAB;
    localparam logic [11:0] REF_CTRL_ADDR     = {2'b00, REF_CTRL_IDX, 2'b00};
    localparam logic [11:0] CTRL_STATUS_ADDR  = {2'b00, CTRL_STATUS_IDX, 2'b00};
    // interrupt enable, sticky status and write-only clear
    localparam logic [11:0] INT_ENABLE_ADDR   = 12'h000;
    localparam logic [11:0] INT_STATUS_ADDR   = 12'h004;
    localparam logic [11:0] INT_CLEAR_ADDR    = 12'h008;

    // field positions
    localparam int          EVENT_FLAG_BIT    = 4;
    localparam int          IRQ_B_BIT         = 6;

    // reset values
    localparam logic [7:0]  CTRL_STATUS_RESET = 8'hC0;
    localparam logic [7:0]  REF_CTRL_RESET    = 8'h00;
    localparam logic [7:0]  INT_ENABLE_RESET  = 8'h00;

    // axi response codes
    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;

    // event mode encodings
    localparam logic [2:0]  MODE_LOW          = 3'b000;
    localparam logic [2:0]  MODE_RISE         = 3'b001;
    localparam logic [2:0]  MODE_DEB_TOGGLE   = 3'b010;
    localparam logic [2:0]  MODE_DEB_RISE     = 3'b011;
    localparam logic [2:0]  MODE_FALL         = 3'b100;
    localparam logic [2:0]  MODE_TOGGLE       = 3'b101;
    localparam logic [2:0]  MODE_DEB_FALL     = 3'b110;
    localparam logic [2:0]  MODE_HIGH         = 3'b111;

    // negative channel code that uses an external pin (pin index 2)
    localparam logic [1:0]  NEG_PIN_CODE      = 2'b00;
    localparam int          NEG_PIN_INDEX     = 2;
    localparam int          PIN_COUNT         = 4;

    // control and status register layout
    typedef struct packed {
        logic [1:0] pos_channel_sel_b;
        logic       input_connect_b;
        logic       event_flag_b;
        logic       comparator_enable_b;
        logic [2:0] event_mode_b_sel;
    } ctrl_status_t;

    // reference control register layout
    typedef struct packed {
        logic       output_copy_b;
        logic       output_copy_a;
        logic [1:0] neg_channel_sel_b;
        logic [1:0] comparator_clock_sel;
        logic [1:0] neg_channel_sel_a;
    } ref_ctrl_t;

    // sampler state
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic tick_sample;
        logic debounced;
    } sampler_state_t;

    localparam sampler_state_t SAMPLER_RESET = '0;

    // state of the top module, apart from the comparator a sync and the sampler
    typedef struct packed {
        ctrl_status_t ctrl;
        ref_ctrl_t    refc;
        logic [7:0]   ie;
        logic         prev_live;
        logic         prev_deb;
        logic         connect_q;
        logic         comp_out_q;
        logic [3:0]   dig_dis_q;
        logic         irq_q;
        logic         awready;
        logic         wready;
        logic         aw_held;
        logic         w_held;
        logic [11:0]  aw_addr;
        logic [7:0]   wdata;
        logic         wlane0;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         arready;
        logic         rvalid;
        logic [7:0]   rdata;
        logic [1:0]   rresp;
    } top_state_t;

    localparam top_state_t TOP_RESET = '{
        ctrl:      ctrl_status_t'(CTRL_STATUS_RESET),
        refc:      ref_ctrl_t'(REF_CTRL_RESET),
        ie:        INT_ENABLE_RESET,
        awready:   1'b1,
        wready:    1'b1,
        arready:   1'b1,
        default:   '0
    };

endpackage

// [hdl/acomp_b_sampler.sv]
// synchroniser and timer-paced debouncer for one comparator output
`timescale 1ns/1ps
module acomp_b_sampler
    import acomp_b_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aclken,
    input  wire logic aresetn,
    input  wire logic raw_in,
    input  wire logic sample_tick,
    output logic      live,
    output logic      debounced
);
    import acomp_b_pkg::*;

    sampler_state_t s;
    sampler_state_t n;

    // two-stage sync, then accept a value seen on two ticks in a row
    always_comb
    begin
        n = s;
        n.sync1 = raw_in;
        n.sync2 = s.sync1;
        if (sample_tick)
        begin
            n.tick_sample = s.sync2;
            if (s.tick_sample == s.sync2)
            begin
                n.debounced = s.sync2;
            end
        end
    end

    // state register with clock enable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= SAMPLER_RESET;
        end
        else if (aclken)
        begin
            s <= n;
        end
    end

    assign live      = s.sync2;
    assign debounced = s.debounced;

endmodule

// [hdl/acomp_b_ctrl.sv]
// control registers and event logic of analog comparator b
//
// Overview of operation
// R01 - Software clears the connect bit before changing either channel select.
// R02 - The selected analog pins reach the comparator only while connect is 1.
// R03 - The event flag sets only when enabled and the chosen mode condition holds.
// R04 - Hardware never clears the event flag; software clears it.
// R05 - The flag becomes an interrupt only while enable register bit 6 is set.
// R06 - With the enable bit clear the output reads low and no events occur.
// R07 - While enabled, digital inputs of the pins in use are disabled.
// R08 - Mode codes: low, rise, deb toggle, deb rise, fall, toggle, deb fall, high.
// R09 - Debounced modes are paced by timer 1, which software keeps running.
// R10 - A readable bit holds the raw comparator b output on the system clock.
// R11 - Edges compare the current sample with the one a cycle earlier.
`timescale 1ns/1ps
module acomp_b_ctrl
    import acomp_b_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aclken,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        comp_b_raw,
    input  wire logic        comp_a_raw,
    input  wire logic        timer1_overflow,
    output logic             input_connect_b,
    output logic [1:0]       pos_channel_sel_b,
    output logic [1:0]       neg_channel_sel_b,
    output logic             comparator_enable_b,
    output logic             comp_b_out,
    output logic [3:0]       digital_input_disable,
    output logic             irq
);
    import acomp_b_pkg::*;

    top_state_t  s;
    top_state_t  n;
    logic        live_b;
    logic        deb_b;
    logic        live_a;
    logic        comp_a_s1;
    logic        comp_a_s2;
    logic        cur_live;
    logic        cur_deb;
    logic        mode_hit;
    logic        event_b;
    logic        flag_clr;
    logic        wr_fire;
    logic        wr_ok;
    logic [7:0]  rd_val;
    logic        rd_ok;
    logic [3:0]  pin_use;

    // comparator b sampling, debounce paced by the timer 1 overflow
    acomp_b_sampler u_sampler_b (
        .aclk        (aclk),
        .aclken      (aclken),
        .aresetn     (aresetn),
        .raw_in      (comp_b_raw),
        .sample_tick (timer1_overflow), // see R09
        .live        (live_b),
        .debounced   (deb_b)
    );

    // comparator a is only mirrored, two-stage sync
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            comp_a_s1 <= 1'b0;
            comp_a_s2 <= 1'b0;
        end
        else if (aclken)
        begin
            comp_a_s1 <= comp_a_raw;
            comp_a_s2 <= comp_a_s1;
        end
    end
    assign live_a = comp_a_s2;

    // gated comparator value, low while disabled
    assign cur_live = s.ctrl.comparator_enable_b & live_b; // see R06
    assign cur_deb  = s.ctrl.comparator_enable_b & deb_b;  // see R06

    // mode condition against the sample one cycle older
    always_comb
    begin
        case (s.ctrl.event_mode_b_sel) // see R08
            MODE_LOW:        mode_hit = ~cur_live;
            MODE_RISE:       mode_hit = cur_live & ~s.prev_live;  // see R11
            MODE_DEB_TOGGLE: mode_hit = cur_deb ^ s.prev_deb;     // see R09
            MODE_DEB_RISE:   mode_hit = cur_deb & ~s.prev_deb;    // see R09
            MODE_FALL:       mode_hit = ~cur_live & s.prev_live;  // see R11
            MODE_TOGGLE:     mode_hit = cur_live ^ s.prev_live;   // see R11
            MODE_DEB_FALL:   mode_hit = ~cur_deb & s.prev_deb;    // see R09
            MODE_HIGH:       mode_hit = cur_live;
            default:         mode_hit = 1'b0;
        endcase
    end

    // events only while enabled
    assign event_b = s.ctrl.comparator_enable_b & mode_hit; // see R03

    // pins in use: the positive channel pin, and pin 2 when the minus side selects NEG_PIN_CODE
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++)
        begin : g_pin
            assign pin_use[gi] =
                (s.ctrl.pos_channel_sel_b == 2'(gi)) |
                ((gi == NEG_PIN_INDEX) &&
                 (s.refc.neg_channel_sel_b == NEG_PIN_CODE));
        end
    endgenerate

    // write decode of the held address and data
    assign wr_fire = s.aw_held & s.w_held & ~s.bvalid;
    always_comb
    begin
        wr_ok    = 1'b1;
        flag_clr = 1'b0;
        if (s.aw_addr == CTRL_STATUS_ADDR)
        begin
            flag_clr = s.wlane0 & ~s.wdata[EVENT_FLAG_BIT];
        end
        else if (s.aw_addr == INT_CLEAR_ADDR)
        begin
            flag_clr = s.wlane0 & s.wdata[IRQ_B_BIT];
        end
        else if (s.aw_addr == REF_CTRL_ADDR)
        begin
            wr_ok = 1'b1;
        end
        else if (s.aw_addr == INT_ENABLE_ADDR)
        begin
            wr_ok = 1'b1;
        end
        else if (s.aw_addr == INT_STATUS_ADDR)
        begin
            wr_ok = 1'b1; // read-only, write ignored
        end
        else
        begin
            wr_ok = 1'b0;
        end
        flag_clr = flag_clr & wr_fire;
    end

    // read decode
    always_comb
    begin
        rd_val = 8'h00;
        rd_ok  = 1'b1;
        if (s_axi_araddr == CTRL_STATUS_ADDR)
        begin
            rd_val = s.ctrl;
        end
        else if (s_axi_araddr == REF_CTRL_ADDR)
        begin
            rd_val = s.refc;
        end
        else if (s_axi_araddr == INT_ENABLE_ADDR)
        begin
            rd_val = s.ie;
        end
        else if (s_axi_araddr == INT_STATUS_ADDR)
        begin
            rd_val[IRQ_B_BIT] = s.ctrl.event_flag_b;
        end
        else if (s_axi_araddr == INT_CLEAR_ADDR)
        begin
            rd_val = 8'h00; // write-only
        end
        else
        begin
            rd_ok = 1'b0;
        end
    end

    // next state
    always_comb
    begin
        n = s;

        // raw output copies, the comparator b copy forced low when disabled
        n.refc.output_copy_b = cur_live; // see R10
        n.refc.output_copy_a = live_a;
        n.prev_live          = cur_live; // see R11
        n.prev_deb           = cur_deb;

        // write channels, taken in either order
        if (s_axi_awvalid && s.awready)
        begin
            n.aw_held = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready)
        begin
            n.w_held = 1'b1;
            n.wdata  = s_axi_wdata[7:0];
            n.wlane0 = s_axi_wstrb[0];
        end
        if (wr_fire)
        begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (s.wlane0 && s.aw_addr == CTRL_STATUS_ADDR)
            begin
                n.ctrl.pos_channel_sel_b   = s.wdata[7:6];
                n.ctrl.input_connect_b     = s.wdata[5];
                n.ctrl.comparator_enable_b = s.wdata[3];
                n.ctrl.event_mode_b_sel    = s.wdata[2:0];
            end
            else if (s.wlane0 && s.aw_addr == REF_CTRL_ADDR)
            begin
                n.refc.neg_channel_sel_b    = s.wdata[5:4];
                n.refc.comparator_clock_sel = s.wdata[3:2];
                n.refc.neg_channel_sel_a    = s.wdata[1:0];
            end
            else if (s.wlane0 && s.aw_addr == INT_ENABLE_ADDR)
            begin
                n.ie = s.wdata;
            end
        end
        if (s.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        n.awready = ~n.aw_held & ~n.bvalid;
        n.wready  = ~n.w_held & ~n.bvalid;

        // sticky flag, only software clears it, a new event wins
        n.ctrl.event_flag_b = event_b |
            (s.ctrl.event_flag_b & ~flag_clr); // see R04

        // read channel
        if (s_axi_arvalid && s.arready)
        begin
            n.arready = 1'b0;
            n.rvalid  = 1'b1;
            n.rdata   = rd_val;
            n.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s.rvalid && s_axi_rready)
        begin
            n.rvalid  = 1'b0;
            n.arready = 1'b1;
        end

        // pin and interrupt outputs
        n.connect_q  = s.ctrl.input_connect_b; // see R02
        n.comp_out_q = cur_live;               // see R06
        n.dig_dis_q  = s.ctrl.comparator_enable_b ? pin_use : 4'h0; // see R07
        n.irq_q      = s.ctrl.event_flag_b & s.ie[IRQ_B_BIT];       // see R05
    end

    // single state register for all but the comparator a sync and the sampler
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= TOP_RESET;
        end
        else if (aclken)
        begin
            s <= n;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready         = s.awready;
    assign s_axi_wready          = s.wready;
    assign s_axi_bvalid          = s.bvalid;
    assign s_axi_bresp           = s.bresp;
    assign s_axi_arready         = s.arready;
    assign s_axi_rvalid          = s.rvalid;
    assign s_axi_rresp           = s.rresp;
    assign s_axi_rdata           = {24'h00_0000, s.rdata};
    assign input_connect_b       = s.connect_q;
    assign pos_channel_sel_b     = s.ctrl.pos_channel_sel_b;
    assign neg_channel_sel_b     = s.refc.neg_channel_sel_b;
    assign comparator_enable_b   = s.ctrl.comparator_enable_b;
    assign comp_b_out            = s.comp_out_q;
    assign digital_input_disable = s.dig_dis_q;
    assign irq                   = s.irq_q;

endmodule

// [testbench/acomp_b_ctrl_chk.sv]
// port assertions for the comparator b control block
`timescale 1ns/1ps
module acomp_b_ctrl_chk
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  pos_channel_sel_b,
    input wire logic        comparator_enable_b,
    input wire logic        comp_b_out,
    input wire logic [3:0]  digital_input_disable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // handshake steps, and three cycles with the comparator disabled
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence off3;
        !comparator_enable_b [*3];
    endsequence

    a_write_resp: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_read_resp: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
        else $error("upper read data not zero");
    a_out_low: assert property (off3 |-> !comp_b_out)
        else $error("output high while disabled");
    a_pins_free: assert property (!comparator_enable_b && $past(!comparator_enable_b)
        |-> digital_input_disable == 4'h0)
        else $error("digital input off while disabled");
    a_pin_off: assert property (comparator_enable_b && $stable(comparator_enable_b)
        && $stable(pos_channel_sel_b)
        |-> digital_input_disable[pos_channel_sel_b])
        else $error("selected pin digital input on");
endmodule

bind acomp_b_ctrl acomp_b_ctrl_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .pos_channel_sel_b, .comparator_enable_b, .comp_b_out,
    .digital_input_disable);

// [testbench/acomp_b_pins.sv]
// behavioural model of the analog pins feeding both comparators
`timescale 1ns/1ps
module acomp_b_pins
(
    input  wire logic aclk,
    input  wire logic connect,
    input  wire logic level_b,
    input  wire logic level_a,
    output logic      comp_b_raw,
    output logic      comp_a_raw
);
    logic float_q = 1'b0;

    // a disconnected input floats, so its output wanders every cycle
    always @(posedge aclk)
        float_q <= ~float_q;

    // outputs settle off the clock edge, unrelated to sampling
    assign #1.3 comp_b_raw = connect ? level_b : float_q;
    assign #0.7 comp_a_raw = level_a;
endmodule

// [testbench/analog_comparator_b_event_logic_bench.sv]
// self-checking bench for the comparator b control block
`timescale 1ns/1ps
module analog_comparator_b_event_logic_bench;
    import acomp_b_pkg::*;
    logic        aclk = 1'b0;
    logic        timer1_overflow = 1'b0;
    logic        aresetn, aclken, level_b, level_a, lv, ie6, ef, la;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        comp_b_raw, comp_a_raw, input_connect_b;
    logic        comparator_enable_b, comp_b_out;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, digital_input_disable;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, n;
    logic [1:0]  pos_channel_sel_b, neg_channel_sel_b;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    acomp_b_ctrl dut (.aclk, .aclken, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comp_b_raw, .comp_a_raw,
        .timer1_overflow, .input_connect_b, .pos_channel_sel_b,
        .neg_channel_sel_b, .comparator_enable_b, .comp_b_out,
        .digital_input_disable, .irq);
    acomp_b_pins pins (.aclk, .connect(input_connect_b), .level_b, .level_a,
        .comp_b_raw, .comp_a_raw);

    always #2 aclk = ~aclk;

    // timer 1 keeps overflowing every third cycle, pacing debounce
    always @(posedge aclk)
        timer1_overflow <= (cycles % 3 == 0);

    // hang guard
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one write, address and data offered together
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= 32'(d);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rdr(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // masked read compare
    task automatic rchk(input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        rdr(a);
        chk(32'(rs), 32'(RESP_OKAY));
        chk(rd & m, e);
    endtask

    // flag after a change of the comparator to level nv
    function automatic logic exp_flag(input logic [2:0] m, input logic nv);
        case (m)
            MODE_LOW, MODE_FALL, MODE_DEB_FALL: return !nv;
            MODE_TOGGLE, MODE_DEB_TOGGLE:       return 1'b1;
            default:                            return nv;
        endcase
    endfunction

    function automatic logic [3:0] exp_dis(input logic [1:0] p,
                                           input logic [1:0] ng);
        exp_dis = 4'h1 << p;
        if (ng == NEG_PIN_CODE)
            exp_dis[NEG_PIN_INDEX] = 1'b1;
    endfunction

    // main sequence
    initial
    begin
        aresetn = 1'b0;
        aclken = 1'b1;
        level_b = 1'b0;
        level_a = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        void'($urandom(68371));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(CTRL_STATUS_ADDR, 32'hFF, 32'(CTRL_STATUS_RESET));
        rchk(REF_CTRL_ADDR, 32'hFF, 32'(REF_CTRL_RESET));
        rchk(INT_ENABLE_ADDR, 32'hFF, 32'(INT_ENABLE_RESET));
        chk(32'(irq), 32'h0);
        rdr(12'h100);
        chk(32'(rs), 32'(RESP_SLVERR));
        wr(12'h100, 8'hFF, RESP_SLVERR);
        wr(CTRL_STATUS_ADDR, 8'h20, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(input_connect_b), 32'h1);
        wr(CTRL_STATUS_ADDR, 8'h00, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(input_connect_b), 32'h0);
        for (int p = 0; p < PIN_COUNT; p++)
        begin
            n = 2'($urandom_range(3));
            wr(REF_CTRL_ADDR, {2'b00, n, 4'h0}, RESP_OKAY);
            wr(CTRL_STATUS_ADDR, {p[1:0], 6'h08}, RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk(32'(neg_channel_sel_b), 32'(n));
            chk(32'(digital_input_disable), 32'(exp_dis(p[1:0], n)));
        end
        wr(CTRL_STATUS_ADDR, 8'h00, RESP_OKAY);
        for (int m = 0; m < 8; m++)
        begin
            lv = 1'($urandom_range(1));
            ie6 = 1'($urandom_range(1));
            level_b <= lv;
            la = 1'($urandom_range(1));
            level_a <= la;
            wr(INT_ENABLE_ADDR, {1'b0, ie6, 6'h00}, RESP_OKAY);
            wr(CTRL_STATUS_ADDR, {5'b00101, m[2:0]}, RESP_OKAY);
            repeat (16) @(posedge aclk);
            wr(INT_CLEAR_ADDR, 8'h40, RESP_OKAY);
            ef = (m == 0 || m == 7) && exp_flag(m[2:0], lv);
            rchk(INT_STATUS_ADDR, 32'h40, 32'(ef) << 6);
            level_b <= !lv;
            repeat (16) @(posedge aclk);
            ef = exp_flag(m[2:0], !lv);
            chk(32'(comp_b_out), 32'(!lv));
            chk(32'(irq), 32'(ie6 & ef));
            rchk(INT_STATUS_ADDR, 32'h40, 32'(ef) << 6);
            rchk(CTRL_STATUS_ADDR, 32'h10, 32'(ef) << 4);
            rchk(REF_CTRL_ADDR, 32'h80, 32'(!lv) << 7);
            rchk(REF_CTRL_ADDR, 32'h40, 32'(la) << 6);
        end
        wr(CTRL_STATUS_ADDR, 8'h25, RESP_OKAY);
        wr(INT_CLEAR_ADDR, 8'h40, RESP_OKAY);
        repeat (4)
        begin
            level_b <= !level_b;
            repeat (8) @(posedge aclk);
        end
        chk(32'(comp_b_out), 32'h0);
        rchk(INT_STATUS_ADDR, 32'h40, 32'h0);
        print_verdict();
    end
endmodule
